// File: verilog/lis_led_top.sv
`timescale 1ns/1ps
`include "lis_consts.svh"

// Contract
// - first mode bits 15:12, reset 0000, speed
// - codes 0001 transmit, 0011 collision, stretched
// - code 0101 shows duplex, not stretched
// - code 0111 shows activity, stretched
// - 1000 on, 1001 off, 1010 fast blink
// - second mode bits 11:8, reset 0100, link
// - second code 1011 blinks slowly
// - second code 1100 link plus receive
// - first code 1110 link plus activity
// - first code 1111 duplex plus collision
// - link solid on, receive/activity blinks
// - full duplex solid on, collision blinks
// - combined modes always stretched
// - bit 1 enables stretching, resets set
// - duration 30/60/100 ms, 11 reserved
module lis_led_top
	import lis_pkg::*;
#(
	parameter int unsigned STR0_CYC  = `LIS_STR0_MS * `LIS_CLK_KHZ,       // 30 ms
	parameter int unsigned STR1_CYC  = `LIS_STR1_MS * `LIS_CLK_KHZ,       // 60 ms
	parameter int unsigned STR2_CYC  = `LIS_STR2_MS * `LIS_CLK_KHZ,       // 100 ms
	parameter int unsigned FAST_CYC  = `LIS_FAST_HALF_MS * `LIS_CLK_KHZ,  // fast half period
	parameter int unsigned SLOW_CYC  = `LIS_SLOW_HALF_MS * `LIS_CLK_KHZ   // slow half period
)
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        regWrEn,
	input  wire logic [4:0]  regAddr,
	input  wire logic [15:0] regWrData,
	output logic      [15:0] regRdData,
	input  wire logic        linkUp,
	input  wire logic        speed100,
	input  wire logic        fullDuplex,
	input  wire logic        txEvent,
	input  wire logic        rxEvent,
	input  wire logic        colEvent,
	output logic             firstIndicator,
	output logic             secondIndicator
);

	lis_top_s state_reg;   // registered state
	lis_top_s state_next;  // next state
	lis_cnt_t stretchLoad; // selected stretch length
	logic     cfgHit;      // address decodes to config word

	// stretch length for a duration code
	function automatic lis_cnt_t durCycles(input logic [1:0] sel);
		lis_cnt_t cyc;
		cyc = lis_cnt_t'(STR0_CYC);
		unique case (sel)
			2'h0: cyc = lis_cnt_t'(STR0_CYC);
			2'h1: cyc = lis_cnt_t'(STR1_CYC);
			2'h2: cyc = lis_cnt_t'(STR2_CYC);
			2'h3: cyc = lis_cnt_t'(STR0_CYC); // reserved code
		endcase
		return cyc;
	endfunction : durCycles

	// packs the stored fields into the register word
	function automatic logic [15:0] cfgWord(input lis_top_s s);
		logic [15:0] w;
		w = 16'h0000;
		w[`LIS_FIRST_HI:`LIS_FIRST_LO] = s.firstMode;
		w[`LIS_SECOND_HI:`LIS_SECOND_LO] = s.secondMode;
		w[`LIS_THIRD_HI:`LIS_THIRD_LO] = s.thirdMode;
		w[`LIS_DUR_HI:`LIS_DUR_LO] = s.durSel;
		w[`LIS_PULSE_BIT] = s.pulseEn;
		return w;
	endfunction : cfgWord

	assign cfgHit = (regAddr == `LIS_CFG_ADDR);
	assign stretchLoad = durCycles(state_reg.durSel);

	// register writes, read data and blink timers
	always_comb
	begin
		state_next = state_reg;
		if (regWrEn && cfgHit)
		begin
			state_next.firstMode = regWrData[`LIS_FIRST_HI:`LIS_FIRST_LO];
			state_next.secondMode = regWrData[`LIS_SECOND_HI:`LIS_SECOND_LO];
			state_next.thirdMode = regWrData[`LIS_THIRD_HI:`LIS_THIRD_LO];
			state_next.durSel = regWrData[`LIS_DUR_HI:`LIS_DUR_LO];
			state_next.pulseEn = regWrData[`LIS_PULSE_BIT];
		end
		// other addresses read zero
		state_next.rdData = cfgHit ? cfgWord(state_reg) : 16'h0000;
		// fast blink toggles each half period
		if (state_reg.fastCnt >= lis_cnt_t'(FAST_CYC - 1))
		begin
			state_next.fastCnt = '0;
			state_next.fastPhase = !state_reg.fastPhase;
		end
		else
		begin
			state_next.fastCnt = state_reg.fastCnt + lis_cnt_t'(1);
		end
		// slow blink toggles each half period
		if (state_reg.slowCnt >= lis_cnt_t'(SLOW_CYC - 1))
		begin
			state_next.slowCnt = '0;
			state_next.slowPhase = !state_reg.slowPhase;
		end
		else
		begin
			state_next.slowCnt = state_reg.slowCnt + lis_cnt_t'(1);
		end
	end

	// state register with documented defaults
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg <= '0;
			state_reg.firstMode <= `LIS_FIRST_RST;
			state_reg.secondMode <= `LIS_SECOND_RST;
			state_reg.thirdMode <= `LIS_THIRD_RST;
			state_reg.durSel <= `LIS_DUR_RST;
			state_reg.pulseEn <= `LIS_PULSE_RST;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign regRdData = state_reg.rdData;

	// first indicator driver
	lis_indicator #(
		.IS_FIRST (1'b1)
	) uFirst (
		.mclk        (mclk),
		.rst_b       (rst_b),
		.mode        (state_reg.firstMode),
		.pulseEn     (state_reg.pulseEn),
		.stretchLoad (stretchLoad),
		.fastPhase   (state_reg.fastPhase),
		.slowPhase   (state_reg.slowPhase),
		.linkUp      (linkUp),
		.speed100    (speed100),
		.fullDuplex  (fullDuplex),
		.txEvent     (txEvent),
		.rxEvent     (rxEvent),
		.colEvent    (colEvent),
		.led         (firstIndicator)
	);

	// second indicator driver
	lis_indicator #(
		.IS_FIRST (1'b0)
	) uSecond (
		.mclk        (mclk),
		.rst_b       (rst_b),
		.mode        (state_reg.secondMode),
		.pulseEn     (state_reg.pulseEn),
		.stretchLoad (stretchLoad),
		.fastPhase   (state_reg.fastPhase),
		.slowPhase   (state_reg.slowPhase),
		.linkUp      (linkUp),
		.speed100    (speed100),
		.fullDuplex  (fullDuplex),
		.txEvent     (txEvent),
		.rxEvent     (rxEvent),
		.colEvent    (colEvent),
		.led         (secondIndicator)
	);

endmodule : lis_led_top

// File: verilog/lis_consts.svh
`ifndef LIS_CONSTS_SVH
`define LIS_CONSTS_SVH

// register address of the indicator configuration word
`define LIS_CFG_ADDR      5'h14
// field positions inside the configuration word
`define LIS_FIRST_HI      15
`define LIS_FIRST_LO      12
`define LIS_SECOND_HI     11
`define LIS_SECOND_LO     8
`define LIS_THIRD_HI      7
`define LIS_THIRD_LO      4
`define LIS_DUR_HI        3
`define LIS_DUR_LO        2
`define LIS_PULSE_BIT     1
// reset values of the fields
`define LIS_FIRST_RST     4'h0
`define LIS_SECOND_RST    4'h4
`define LIS_THIRD_RST     4'h2
`define LIS_DUR_RST       2'h0
`define LIS_PULSE_RST     1'h1
// clock rate and nominal times
`define LIS_CLK_KHZ       125000
`define LIS_STR0_MS       30
`define LIS_STR1_MS       60
`define LIS_STR2_MS       100
`define LIS_FAST_HALF_MS  50
`define LIS_SLOW_HALF_MS  250
// counter width, wide enough for the longest time
`define LIS_CNT_W         28

`endif

// File: verilog/lis_pkg.sv
`include "lis_consts.svh"

package lis_pkg;

	// display mode codes of one indicator field
	typedef enum logic [3:0] {
		MODE_SPEED    = 4'h0,
		MODE_TX       = 4'h1,
		MODE_RX       = 4'h2,
		MODE_COL      = 4'h3,
		MODE_LINK     = 4'h4,
		MODE_DUPLEX   = 4'h5,
		MODE_UNUSED6  = 4'h6,
		MODE_ACT      = 4'h7,
		MODE_ON       = 4'h8,
		MODE_OFF      = 4'h9,
		MODE_FAST     = 4'ha,
		MODE_SLOW     = 4'hb,
		MODE_LINK_RX  = 4'hc,
		MODE_CODE_D   = 4'hd,
		MODE_CODE_E   = 4'he,
		MODE_CODE_F   = 4'hf
	} lis_mode_e;

	typedef logic [`LIS_CNT_W-1:0] lis_cnt_t;

	// state of one indicator driver
	typedef struct packed {
		lis_cnt_t stretchCnt; // remaining stretch time
		logic     led;        // registered indicator level
	} lis_drv_s;

	// state of the top block
	typedef struct packed {
		logic [3:0]  firstMode;  // first indicator mode
		logic [3:0]  secondMode; // second indicator mode
		logic [3:0]  thirdMode;  // stored only
		logic [1:0]  durSel;     // stretch duration select
		logic        pulseEn;    // global stretch enable
		lis_cnt_t    fastCnt;    // fast blink timer
		lis_cnt_t    slowCnt;    // slow blink timer
		logic        fastPhase;  // fast blink level
		logic        slowPhase;  // slow blink level
		logic [15:0] rdData;     // read data register
	} lis_top_s;

endpackage : lis_pkg

// File: verilog/lis_indicator.sv
`timescale 1ns/1ps
`include "lis_consts.svh"

// one indicator: selects a status, stretches events, mixes combined modes
module lis_indicator
	import lis_pkg::*;
#(
	parameter bit IS_FIRST = 1'b1 // first indicator decodes 1110/1111 combined
)
(
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic [3:0] mode,
	input  wire logic       pulseEn,
	input  wire lis_cnt_t   stretchLoad,
	input  wire logic       fastPhase,
	input  wire logic       slowPhase,
	input  wire logic       linkUp,
	input  wire logic       speed100,
	input  wire logic       fullDuplex,
	input  wire logic       txEvent,
	input  wire logic       rxEvent,
	input  wire logic       colEvent,
	output logic            led
);

	lis_drv_s state_reg;  // registered state
	lis_drv_s state_next; // next state
	logic     evt;        // selected raw event
	logic     primary;    // solid driver of combined modes
	logic     combined;   // combined mode active
	logic     stretched;  // event after stretching

	// decode mode, stretch, form indicator level
	always_comb
	begin
		state_next = state_reg;
		evt = 1'b0;
		primary = 1'b0;
		combined = 1'b0;
		unique case (mode)
			MODE_TX:      evt = txEvent;
			MODE_COL:     evt = colEvent;
			MODE_RX:      evt = rxEvent;
			MODE_ACT:     evt = rxEvent | txEvent;
			MODE_LINK_RX:
			begin
				combined = 1'b1;
				primary = linkUp;
				evt = rxEvent;
			end
			MODE_CODE_D:
			begin
				combined = !IS_FIRST;
				primary = linkUp;
				evt = IS_FIRST ? 1'b0 : (rxEvent | txEvent); // unused code of the first field
			end
			MODE_CODE_E:
			begin
				combined = 1'b1;
				primary = IS_FIRST ? linkUp : fullDuplex;
				evt = IS_FIRST ? (rxEvent | txEvent) : colEvent;
			end
			MODE_CODE_F:
			begin
				combined = IS_FIRST;
				primary = fullDuplex;
				evt = IS_FIRST ? colEvent : 1'b0; // unused code of the second field
			end
			default:      evt = 1'b0;
		endcase
		// each event restarts the count
		if (evt)
		begin
			state_next.stretchCnt = stretchLoad;
		end
		else if (state_reg.stretchCnt != '0)
		begin
			state_next.stretchCnt = state_reg.stretchCnt - lis_cnt_t'(1);
		end
		// combined modes stretch whatever the enable says
		if (pulseEn || combined)
		begin
			stretched = evt || (state_reg.stretchCnt != '0);
		end
		else
		begin
			stretched = evt;
		end
		unique case (mode)
			MODE_SPEED:   state_next.led = speed100;
			MODE_LINK:    state_next.led = linkUp;
			MODE_DUPLEX:  state_next.led = fullDuplex;
			MODE_ON:      state_next.led = 1'b1;
			MODE_OFF:     state_next.led = 1'b0;
			MODE_FAST:    state_next.led = fastPhase;
			MODE_SLOW:    state_next.led = slowPhase;
			MODE_UNUSED6: state_next.led = 1'b0;
			default:
			begin
				if (combined)
				begin
					// solid on, blinks while secondary events run
					state_next.led = primary && (!stretched || fastPhase);
				end
				else
				begin
					state_next.led = stretched;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign led = state_reg.led;

endmodule : lis_indicator

// File: tb/lis_led_monitor.sv
`timescale 1ns/1ps
// checks indicator levels against a shadow of the written modes
module lis_led_monitor
	import lis_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic        regWrEn,
	input wire logic [4:0]  regAddr,
	input wire logic [15:0] regWrData,
	input wire logic [15:0] regRdData,
	input wire logic        linkUp,
	input wire logic        speed100,
	input wire logic        fullDuplex,
	input wire logic        txEvent,
	input wire logic        rxEvent,
	input wire logic        colEvent,
	input wire logic        firstIndicator,
	input wire logic        secondIndicator
);
	logic [15:0] cfgReg; // shadow of the configuration word
	logic [3:0]  mode1;  // first field of the shadow
	logic [3:0]  mode2;  // second field of the shadow
	assign mode1 = cfgReg[15:12];
	assign mode2 = cfgReg[11:8];
	// follow writes the way the block takes them
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			cfgReg <= 16'h0422;
		else if (regWrEn && regAddr == 5'h14)
			cfgReg <= regWrData & 16'hfffe;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	property p_speed; mode1 == 4'h0 |=> firstIndicator == $past(speed100); endproperty
	a_speed: assert property (p_speed) else $error("speed not shown");
	property p_dup; mode1 == 4'h5 |=> firstIndicator == $past(fullDuplex); endproperty
	a_dup: assert property (p_dup) else $error("duplex not shown");
	property p_force; mode1 inside {4'h8, 4'h9} |=> firstIndicator == !$past(cfgReg[12]); endproperty
	a_force: assert property (p_force) else $error("forced level wrong");
	property p_link; mode2 == 4'h4 |=> secondIndicator == $past(linkUp); endproperty
	a_link: assert property (p_link) else $error("link not shown");
	property p_hold; mode1 == 4'h1 && cfgReg[1] && txEvent ##1 mode1 == 4'h1 && !txEvent
		|=> firstIndicator; endproperty
	a_hold: assert property (p_hold) else $error("event not stretched");
	property p_raw; mode1 == 4'h1 && !cfgReg[1] |=> firstIndicator == $past(txEvent); endproperty
	a_raw: assert property (p_raw) else $error("raw event not followed");
	property p_lnkact; mode1 == 4'he && !linkUp |=> !firstIndicator; endproperty
	a_lnkact: assert property (p_lnkact) else $error("lit with link down");
	property p_dupcol; mode1 == 4'hf && !fullDuplex |=> !firstIndicator; endproperty
	a_dupcol: assert property (p_dupcol) else $error("lit at half duplex");
	property p_lnkrx; mode2 == 4'hc && !linkUp |=> !secondIndicator; endproperty
	a_lnkrx: assert property (p_lnkrx) else $error("second lit, link down");
	property p_rd; regWrEn && regAddr == 5'h14 ##1 regAddr == 5'h14
		|=> regRdData == ($past(regWrData, 2) & 16'hfffe); endproperty
	a_rd: assert property (p_rd) else $error("written word not read");
endmodule : lis_led_monitor

bind lis_led_top lis_led_monitor i_lis_led_monitor (.mclk(mclk), .rst_b(rst_b),
	.regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
	.linkUp(linkUp), .speed100(speed100), .fullDuplex(fullDuplex), .txEvent(txEvent),
	.rxEvent(rxEvent), .colEvent(colEvent), .firstIndicator(firstIndicator),
	.secondIndicator(secondIndicator));

// File: tb/lis_led_model.sv
`timescale 1ns/1ps
// the two leds: counts lit cycles and changes of state while clr is low
module lis_led_model
(
	input  wire logic       mclk,
	input  wire logic       clr,
	input  wire logic [1:0] led,
	output int              litCnt [2],
	output int              chgCnt [2]
);
	logic [1:0] last; // level seen one cycle earlier
	// accumulate, or clear while clr is high
	always_ff @(posedge mclk)
	begin
		last <= led;
		for (int i = 0; i < 2; i++)
		begin
			litCnt[i] <= clr ? 0 : litCnt[i] + int'(led[i] === 1'b1);
			chgCnt[i] <= clr ? 0 : chgCnt[i] + int'(led[i] !== last[i]);
		end
	end
endmodule : lis_led_model

// File: tb/testbench.sv
`timescale 1ns/1ps
// register and indicator scenarios
module testbench;
	import lis_pkg::*;
	localparam int S0 = 20; // shortened stretch counts
	localparam int S1 = 40;
	localparam int S2 = 60;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic        regWrEn = 1'b0;
	logic [4:0]  regAddr = 5'h14;
	logic [15:0] regWrData = 16'h0000;
	logic [15:0] regRdData;
	logic        linkUp = 1'b0;
	logic        speed100 = 1'b0;
	logic        fullDuplex = 1'b0;
	logic [2:0]  ev = 3'h0; // tx, rx, col events
	wire  [1:0]  led;
	logic        clr = 1'b1;
	int          lit [2];
	int          chg [2];
	int          h [4];
	int          errorCnt = 0;
	int          nChecks = 0;
	// 125 MHz clock
	always #4 mclk = ~mclk;
	lis_led_top #(.STR0_CYC(S0), .STR1_CYC(S1), .STR2_CYC(S2), .FAST_CYC(8), .SLOW_CYC(16))
	i_lis_led_top (.mclk(mclk), .rst_b(rst_b), .regWrEn(regWrEn), .regAddr(regAddr),
		.regWrData(regWrData), .regRdData(regRdData), .linkUp(linkUp), .speed100(speed100),
		.fullDuplex(fullDuplex), .txEvent(ev[2]), .rxEvent(ev[1]), .colEvent(ev[0]),
		.firstIndicator(led[0]), .secondIndicator(led[1]));
	lis_led_model i_lis_led_model (.mclk(mclk), .clr(clr), .led(led), .litCnt(lit),
		.chgCnt(chg));
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp)
		begin
			errorCnt++;
			$display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
		end
	endtask : chk
	// one-cycle write strobe
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge mclk);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge mclk);
		regWrEn = 1'b0;
		regAddr = 5'h14;
	endtask : wr
	// read data is registered one cycle after the address
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(negedge mclk);
		regAddr = a;
		@(negedge mclk);
		chk(regRdData, e);
		regAddr = 5'h14;
	endtask : rd
	// write a mode word and compare both levels after it settles
	task automatic lvl(input logic [15:0] d, input logic e1, input logic e2);
		wr(5'h14, d);
		repeat (3) @(negedge mclk);
		chk(led, {e2, e1});
	endtask : lvl
	// fire events for one cycle, then let the leds be counted
	task automatic meas(input logic [2:0] e, input int n);
		@(negedge mclk);
		clr = 1'b0;
		ev = e;
		@(negedge mclk);
		ev = 3'h0;
		repeat (n) @(negedge mclk);
		clr = 1'b1;
	endtask : meas
	// verdict
	task automatic closeOut;
		$display("checks %0d, mismatches %0d", nChecks, errorCnt);
		if (errorCnt == 0 && nChecks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : closeOut
	// hang guard
	initial
	begin
		#160000;
		errorCnt++;
		closeOut();
	end
	// main sequence
	initial
	begin
		repeat (16) @(negedge mclk);
		rst_b = 1'b1;
		rd(5'h14, 16'h0422);
		wr(5'h13, 16'hffff);
		rd(5'h13, 16'h0000);
		rd(5'h14, 16'h0422);
		speed100 = 1'b1;
		linkUp = 1'b1;
		lvl(16'h0402, 1'b1, 1'b1);
		lvl(16'h5402, 1'b0, 1'b1);
		fullDuplex = 1'b1;
		lvl(16'h5402, 1'b1, 1'b1);
		lvl(16'h9402, 1'b0, 1'b1);
		lvl(16'h8402, 1'b1, 1'b1);
		linkUp = 1'b0;
		lvl(16'he402, 1'b0, 1'b0);
		lvl(16'hfc02, 1'b1, 1'b0);
		linkUp = 1'b1;
		// receive with no event, unused and second-field combined codes
		lvl(16'h2602, 1'b0, 1'b0);
		lvl(16'h4d02, 1'b1, 1'b1);
		lvl(16'hde02, 1'b0, 1'b1);
		lvl(16'h6f02, 1'b0, 1'b0);
		for (int d = 0; d < 4; d++)
		begin
			wr(5'h14, {8'h14, 4'h0, 2'(d), 2'b10});
			meas(3'b100, 80);
			h[d] = lit[0];
		end
		chk(h[1] - h[0], S1 - S0);
		chk(h[2] - h[0], S2 - S0);
		chk(h[3], h[0]);
		chk(h[0] >= S0, 1'b1);
		wr(5'h14, 16'h3402);
		meas(3'b001, 80);
		chk(lit[0], h[0]);
		wr(5'h14, 16'h7402);
		meas(3'b010, 80);
		chk(lit[0], h[0]);
		wr(5'h14, 16'h1400);
		meas(3'b100, 80);
		chk(lit[0], 1);
		wr(5'h14, 16'he400);
		meas(3'b000, 40);
		// n counted edges plus the start edge
		chk(lit[0], 41);
		meas(3'b010, 40);
		chk(lit[0] < 36, 1'b1);
		wr(5'h14, 16'h8c02);
		meas(3'b010, 40);
		chk({lit[1] < 36, lit[0] == 41}, 2'b11);
		wr(5'h14, 16'hf402);
		meas(3'b001, 40);
		chk(lit[0] < 36, 1'b1);
		wr(5'h14, 16'hab02);
		meas(3'b000, 64);
		chk({chg[0] > chg[1], chg[1] > 1}, 2'b11);
		closeOut();
	end
endmodule : testbench
